//--- verilog/cmpc_defs.svh
// register offsets, field positions, reset values and select codes
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

`define CMPC_OFS_MIRROR   16'h098F
`define CMPC_OFS_C1_CON0  16'h0990
`define CMPC_OFS_C1_CON1  16'h0991
`define CMPC_OFS_C1_NSEL  16'h0992
`define CMPC_OFS_C1_PSEL  16'h0993
`define CMPC_OFS_C2_CON0  16'h0994
`define CMPC_OFS_C2_CON1  16'h0995
`define CMPC_OFS_C2_NSEL  16'h0996
`define CMPC_OFS_C2_PSEL  16'h0997
`define CMPC_OFS_FLAG     16'h0998
`define CMPC_OFS_IRQ_EN   16'h0999

`define CMPC_BIT_EN       7
`define CMPC_BIT_OUT      6
`define CMPC_BIT_INV      4
`define CMPC_BIT_HYS      1
`define CMPC_BIT_SYNC     0
`define CMPC_BIT_RISE     1
`define CMPC_BIT_FALL     0

`define CMPC_RST_BIT      1'h0
`define CMPC_RST_SEL      3'h0
`define CMPC_RST_BYTE     8'h00

`define CMPC_NSEL_GND     3'h7
`define CMPC_NSEL_REF     3'h6
`define CMPC_NSEL_PIN3    3'h3
`define CMPC_NSEL_PIN2    3'h2
`define CMPC_NSEL_PIN1    3'h1
`define CMPC_NSEL_PIN0    3'h0
`define CMPC_PSEL_GND     3'h7
`define CMPC_PSEL_REF     3'h6
`define CMPC_PSEL_DAC     3'h5
`define CMPC_PSEL_PIN1    3'h1
`define CMPC_PSEL_PIN0    3'h0

`define CMPC_TRIG_C1      2'h1
`define CMPC_TRIG_C2      2'h2

`endif

//--- verilog/cmpc_pkg.sv
// shared types of the comparator control block
package cmpc_pkg;
  typedef logic [7:0]  cmpc_byte_t;
  typedef logic [15:0] cmpc_addr_t;
  typedef logic [2:0]  cmpc_chsel_t;
  typedef logic [1:0]  cmpc_trig_t;
endpackage : cmpc_pkg

//--- verilog/cmpc_sync.sv
// two-flop synchroniser for the raw comparator results
`timescale 1ns/1ps
module cmpc_sync (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // async in, synced out
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : cmpc_sync

//--- verilog/cmpc_edge.sv
// rising and falling edge detector on one level
`timescale 1ns/1ps
module cmpc_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level in, edge pulses out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_reg <= 1'h0;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule : cmpc_edge

//--- verilog/cmpc_ctrl.sv
// digital control and output logic for two analog comparators
//
// Contract
// - active output with enable suspends waveform generator
// - selected comparator rising output starts ADC
// - selected comparator high resets even timer
// - synced outputs stop in sleep on core clock
// - enabled comparator interrupt wakes device
// - mirror register shows both outputs read-only
// - control bit 7 enables comparator, resets 0
// - bit 6 reads result, inverted by polarity
// - control bit 4 inverts output, resets 0
// - control bit 1 enables hysteresis, resets 0
// - sync bit latches output on timer fall
// - rise enable sets flag on rising edge
// - fall enable sets flag on falling edge
// - inverting select codes route ground, reference, pins
// - non-inverting codes route ground, reference, DAC, pins
// - internal output latched each instruction cycle
// - disabled comparator disconnects inputs, output zero; code outputs the polarity bit inv_reg instead
// - flag held until cleared; edge beats clear
// - polarity or enable toggles can raise flag
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module cmpc_ctrl (
  // clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SRST,
  // register port
  input  wire cmpc_pkg::cmpc_addr_t  REG_ADDR,
  input  wire cmpc_pkg::cmpc_byte_t  REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output cmpc_pkg::cmpc_byte_t       REG_RDATA,
  // analog core and timing
  input  wire logic [1:0]            CMP_RAW,
  input  wire logic                  INSTR_CYCLE_EN,
  input  wire logic                  TMR_CLK_FALL_EN,
  input  wire logic                  TMR_SRC_IS_CORE,
  input  wire logic                  SLEEP,
  // partner selections
  input  wire logic [1:0]            SHDN_SRC_EN,
  input  wire cmpc_pkg::cmpc_trig_t  ADC_TRIG_SEL,
  input  wire cmpc_pkg::cmpc_trig_t  TMR_RST_SEL,
  // analog controls
  output logic [1:0]                 ANALOG_EN,
  output logic [1:0]                 HYST_EN,
  output logic [11:0]                NEG_ROUTE,
  output logic [9:0]                 POS_ROUTE,
  // results and events
  output logic [1:0]                 CMP_EXT_OUT,
  output logic                       WG_SUSPEND,
  output logic                       ADC_START,
  output logic                       TMR_RESET,
  output logic [1:0]                 COMP_IRQ,
  output logic                       WAKE
);

  logic [1:0]           raw_s;
  logic [1:0]           int_out;
  logic [1:0]           rise_ev;
  logic [1:0]           fall_ev;
  logic [1:0]           ext_rise;
  logic [1:0]           ext_prev_reg;
  logic [1:0]           flag_reg;
  logic [1:0]           irq_en_reg;
  logic [1:0]           flag_set;
  logic                 sync_latch_en;
  logic                 wr_flag;
  logic                 wr_irq_en;
  logic                 adc_fire;
  logic                 tmr_fire;
  cmpc_pkg::cmpc_byte_t con0_rd [2];
  cmpc_pkg::cmpc_byte_t con1_rd [2];
  cmpc_pkg::cmpc_byte_t nsel_rd [2];
  cmpc_pkg::cmpc_byte_t psel_rd [2];
  cmpc_pkg::cmpc_byte_t rdata_next;

  // raw result crosses in before anything looks at it
  cmpc_sync u_sync (
    .clk      (CORE_CLK),
    .srst     (SRST),
    .async_in (CMP_RAW),
    .sync_out (raw_s)
  );

  // a core-clocked timer is stopped in sleep, so its edges never come
  assign sync_latch_en = TMR_CLK_FALL_EN &
                         ~(SLEEP & TMR_SRC_IS_CORE);

  assign wr_flag   = REG_WR && (REG_ADDR == `CMPC_OFS_FLAG);
  assign wr_irq_en = REG_WR && (REG_ADDR == `CMPC_OFS_IRQ_EN);

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_cmp
      localparam cmpc_pkg::cmpc_addr_t OFS_CON0 =
        (i == 0) ? `CMPC_OFS_C1_CON0 : `CMPC_OFS_C2_CON0;
      localparam cmpc_pkg::cmpc_addr_t OFS_CON1 =
        (i == 0) ? `CMPC_OFS_C1_CON1 : `CMPC_OFS_C2_CON1;
      localparam cmpc_pkg::cmpc_addr_t OFS_NSEL =
        (i == 0) ? `CMPC_OFS_C1_NSEL : `CMPC_OFS_C2_NSEL;
      localparam cmpc_pkg::cmpc_addr_t OFS_PSEL =
        (i == 0) ? `CMPC_OFS_C1_PSEL : `CMPC_OFS_C2_PSEL;

      logic                  en_reg;
      logic                  inv_reg;
      logic                  hys_reg;
      logic                  sync_reg;
      logic                  rise_en_reg;
      logic                  fall_en_reg;
      cmpc_pkg::cmpc_chsel_t nsel_reg;
      cmpc_pkg::cmpc_chsel_t psel_reg;
      logic                  res_reg;
      logic                  ext_reg;
      logic [5:0]            nroute_reg;
      logic [4:0]            proute_reg;
      logic                  value;

      // control register 0 fields
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          en_reg   <= `CMPC_RST_BIT;
          inv_reg  <= `CMPC_RST_BIT;
          hys_reg  <= `CMPC_RST_BIT;
          sync_reg <= `CMPC_RST_BIT;
        end else if (REG_WR && REG_ADDR == OFS_CON0) begin
          en_reg   <= REG_WDATA[`CMPC_BIT_EN];
          inv_reg  <= REG_WDATA[`CMPC_BIT_INV];
          hys_reg  <= REG_WDATA[`CMPC_BIT_HYS];
          sync_reg <= REG_WDATA[`CMPC_BIT_SYNC];
        end
      end

      // control register 1 fields
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          rise_en_reg <= `CMPC_RST_BIT;
          fall_en_reg <= `CMPC_RST_BIT;
        end else if (REG_WR && REG_ADDR == OFS_CON1) begin
          rise_en_reg <= REG_WDATA[`CMPC_BIT_RISE];
          fall_en_reg <= REG_WDATA[`CMPC_BIT_FALL];
        end
      end

      // channel selects
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          nsel_reg <= `CMPC_RST_SEL;
          psel_reg <= `CMPC_RST_SEL;
        end else begin
          if (REG_WR && REG_ADDR == OFS_NSEL) begin
            nsel_reg <= REG_WDATA[2:0];
          end
          if (REG_WR && REG_ADDR == OFS_PSEL) begin
            psel_reg <= REG_WDATA[2:0];
          end
        end
      end

      // disabled core reads as 0 before the polarity stage, so a
      // polarity or enable toggle still moves the output
      assign value = (en_reg & raw_s[i]) ^ inv_reg;

      // internal copy moves once per instruction cycle
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          res_reg <= `CMPC_RST_BIT;
        end else if (INSTR_CYCLE_EN) begin
          res_reg <= value;
        end
      end

      // peripheral copy: timer-synced or passed straight on
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          ext_reg <= `CMPC_RST_BIT;
        end else if (!sync_reg) begin
          ext_reg <= value;
        end else if (sync_latch_en) begin
          ext_reg <= value;
        end
      end

      // inverting input routing: {ground, reference, pin3..pin0}
      always_ff @(posedge CORE_CLK) begin
        if (SRST || !en_reg) begin
          nroute_reg <= 6'h00;
        end else begin
          case (nsel_reg)
            `CMPC_NSEL_GND:  nroute_reg <= 6'h20;
            `CMPC_NSEL_REF:  nroute_reg <= 6'h10;
            `CMPC_NSEL_PIN3: nroute_reg <= 6'h08;
            `CMPC_NSEL_PIN2: nroute_reg <= 6'h04;
            `CMPC_NSEL_PIN1: nroute_reg <= 6'h02;
            `CMPC_NSEL_PIN0: nroute_reg <= 6'h01;
            default:         nroute_reg <= 6'h00;
          endcase
        end
      end

      // non-inverting routing: {ground, reference, dac, pin1, pin0}
      always_ff @(posedge CORE_CLK) begin
        if (SRST || !en_reg) begin
          proute_reg <= 5'h00;
        end else begin
          case (psel_reg)
            `CMPC_PSEL_GND:  proute_reg <= 5'h10;
            `CMPC_PSEL_REF:  proute_reg <= 5'h08;
            `CMPC_PSEL_DAC:  proute_reg <= 5'h04;
            `CMPC_PSEL_PIN1: proute_reg <= 5'h02;
            `CMPC_PSEL_PIN0: proute_reg <= 5'h01;
            default:         proute_reg <= 5'h00;
          endcase
        end
      end

      cmpc_edge u_edge (
        .clk   (CORE_CLK),
        .srst  (SRST),
        .level (res_reg),
        .rise  (rise_ev[i]),
        .fall  (fall_ev[i])
      );

      assign flag_set[i] = (rise_ev[i] & rise_en_reg)
                         | (fall_ev[i] & fall_en_reg);

      // edge in the clearing cycle keeps the flag
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          flag_reg[i] <= `CMPC_RST_BIT;
        end else if (flag_set[i]) begin
          flag_reg[i] <= 1'h1;
        end else if (wr_flag && REG_WDATA[i]) begin
          flag_reg[i] <= 1'h0;
        end
      end

      assign int_out[i]   = res_reg;
      assign ext_rise[i]  = ext_reg & ~ext_prev_reg[i];
      assign CMP_EXT_OUT[i]     = ext_reg;
      assign ANALOG_EN[i]       = en_reg;
      assign HYST_EN[i]         = hys_reg;
      assign NEG_ROUTE[6*i +: 6] = nroute_reg;
      assign POS_ROUTE[5*i +: 5] = proute_reg;

      assign con0_rd[i] = {en_reg, res_reg, 1'h0, inv_reg,
                           2'h0, hys_reg, sync_reg};
      assign con1_rd[i] = {6'h00, rise_en_reg, fall_en_reg};
      assign nsel_rd[i] = {5'h00, nsel_reg};
      assign psel_rd[i] = {5'h00, psel_reg};
    end
  endgenerate

  // software interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_en_reg <= 2'h0;
    end else if (wr_irq_en) begin
      irq_en_reg <= REG_WDATA[1:0];
    end
  end

  // previous peripheral output, for rising edges seen by partners
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ext_prev_reg <= 2'h0;
    end else begin
      ext_prev_reg <= CMP_EXT_OUT;
    end
  end

  // partner events; the converter wants one start per rising output
  assign adc_fire = ((ADC_TRIG_SEL == `CMPC_TRIG_C1) & ext_rise[0])
                  | ((ADC_TRIG_SEL == `CMPC_TRIG_C2) & ext_rise[1]);
  assign tmr_fire = ((TMR_RST_SEL == `CMPC_TRIG_C1) & CMP_EXT_OUT[0])
                  | ((TMR_RST_SEL == `CMPC_TRIG_C2) & CMP_EXT_OUT[1]);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      WG_SUSPEND <= 1'h0;
    end else begin
      WG_SUSPEND <= |(CMP_EXT_OUT & SHDN_SRC_EN);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ADC_START <= 1'h0;
    end else begin
      ADC_START <= adc_fire;
    end
  end

  // held as a level: the timer stays cleared while the output is high
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      TMR_RESET <= 1'h0;
    end else begin
      TMR_RESET <= tmr_fire;
    end
  end

  // pending interrupts and wake request
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      COMP_IRQ <= 2'h0;
      WAKE     <= 1'h0;
    end else begin
      COMP_IRQ <= flag_reg & irq_en_reg;
      WAKE     <= SLEEP & |(flag_reg & irq_en_reg);
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_next = `CMPC_RST_BYTE;
    case (REG_ADDR)
      `CMPC_OFS_MIRROR:  rdata_next = {6'h00, int_out};
      `CMPC_OFS_C1_CON0: rdata_next = con0_rd[0];
      `CMPC_OFS_C1_CON1: rdata_next = con1_rd[0];
      `CMPC_OFS_C1_NSEL: rdata_next = nsel_rd[0];
      `CMPC_OFS_C1_PSEL: rdata_next = psel_rd[0];
      `CMPC_OFS_C2_CON0: rdata_next = con0_rd[1];
      `CMPC_OFS_C2_CON1: rdata_next = con1_rd[1];
      `CMPC_OFS_C2_NSEL: rdata_next = nsel_rd[1];
      `CMPC_OFS_C2_PSEL: rdata_next = psel_rd[1];
      `CMPC_OFS_FLAG:    rdata_next = {6'h00, flag_reg};
      `CMPC_OFS_IRQ_EN:  rdata_next = {6'h00, irq_en_reg};
      default:           rdata_next = `CMPC_RST_BYTE;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      REG_RDATA <= `CMPC_RST_BYTE;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end else begin
      REG_RDATA <= `CMPC_RST_BYTE;
    end
  end

endmodule : cmpc_ctrl

//--- tb/cmpc_ctrl_properties.sv
// port checks for the comparator control block
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module cmpc_ctrl_properties (
  // clock and reset
  input wire logic                 CORE_CLK,
  input wire logic                 SRST,
  // register writes
  input wire cmpc_pkg::cmpc_addr_t REG_ADDR,
  input wire cmpc_pkg::cmpc_byte_t REG_WDATA,
  input wire logic                 REG_WR,
  // timing and selections
  input wire logic                 TMR_CLK_FALL_EN,
  input wire logic                 TMR_SRC_IS_CORE,
  input wire logic                 SLEEP,
  input wire logic [1:0]           SHDN_SRC_EN,
  input wire cmpc_pkg::cmpc_trig_t ADC_TRIG_SEL,
  input wire cmpc_pkg::cmpc_trig_t TMR_RST_SEL,
  // outputs
  input wire logic [1:0]           ANALOG_EN,
  input wire logic [11:0]          NEG_ROUTE,
  input wire logic [9:0]           POS_ROUTE,
  input wire logic [1:0]           CMP_EXT_OUT,
  input wire logic                 WG_SUSPEND,
  input wire logic                 ADC_START,
  input wire logic                 TMR_RESET,
  input wire logic [1:0]           COMP_IRQ,
  input wire logic                 WAKE
);
  logic       sync_reg;
  logic [1:0] ext_prev;
  wire        wg_hit   = |(CMP_EXT_OUT & SHDN_SRC_EN);
  // each output's own rise, so a select change alone starts nothing
  wire  [1:0] ext_rise = CMP_EXT_OUT & ~ext_prev;
  wire        adc_rise = ADC_TRIG_SEL == `CMPC_TRIG_C1 ? ext_rise[0]
                       : (ADC_TRIG_SEL == `CMPC_TRIG_C2) & ext_rise[1];
  wire        tmr_hit  = TMR_RST_SEL == `CMPC_TRIG_C1 ? CMP_EXT_OUT[0]
                       : (TMR_RST_SEL == `CMPC_TRIG_C2) & CMP_EXT_OUT[1];
  // timer stands still in sleep when it runs from the core clock
  wire  frozen   = SLEEP & TMR_SRC_IS_CORE;
  // copy of the comp1 sync bit, taken from the write port
  always_ff @(posedge CORE_CLK) begin
    if (SRST) sync_reg <= 1'b0;
    else if (REG_WR && REG_ADDR == `CMPC_OFS_C1_CON0)
      sync_reg <= REG_WDATA[`CMPC_BIT_SYNC];
  end
  always_ff @(posedge CORE_CLK) begin
    ext_prev <= SRST ? 2'h0 : CMP_EXT_OUT;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  wg_on_a: assert property (wg_hit |-> ##[0:1] WG_SUSPEND)
    else $error("suspend missing");
  wg_cause_a: assert property (
    WG_SUSPEND |-> wg_hit || $past(wg_hit)) else $error("stray suspend");
  adc_start_a: assert property (adc_rise |-> ##[0:1] ADC_START)
    else $error("adc start missing");
  adc_cause_a: assert property (
    ADC_START |-> adc_rise || $past(adc_rise)) else $error("stray adc start");
  tmr_on_a: assert property (tmr_hit |-> ##[0:1] TMR_RESET)
    else $error("timer reset missing");
  tmr_cause_a: assert property (
    TMR_RESET |-> tmr_hit || $past(tmr_hit)) else $error("stray timer reset");
  sync_hold_a: assert property (
    $past(sync_reg) && !$past(TMR_CLK_FALL_EN && !frozen)
    |-> $stable(CMP_EXT_OUT[0])) else $error("sync output moved");
  route_off_a: assert property (
    !ANALOG_EN[0] ##1 !ANALOG_EN[0] |-> NEG_ROUTE[5:0] == 6'h00
    && POS_ROUTE[4:0] == 5'h00) else $error("route while disabled");
  route_hot_a: assert property ($onehot0(NEG_ROUTE[5:0])
    && $onehot0(POS_ROUTE[9:5])) else $error("two routes at once");
  wake_set_a: assert property (
    (SLEEP && COMP_IRQ != 2'h0) [*2] |-> WAKE) else $error("no wake");
  wake_idle_a: assert property (!SLEEP [*2] |-> !WAKE)
    else $error("wake while awake");
endmodule : cmpc_ctrl_properties

bind cmpc_ctrl cmpc_ctrl_properties i_cmpc_ctrl_properties (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .TMR_CLK_FALL_EN(TMR_CLK_FALL_EN), .TMR_SRC_IS_CORE(TMR_SRC_IS_CORE),
  .SLEEP(SLEEP), .SHDN_SRC_EN(SHDN_SRC_EN), .ADC_TRIG_SEL(ADC_TRIG_SEL),
  .TMR_RST_SEL(TMR_RST_SEL), .ANALOG_EN(ANALOG_EN),
  .NEG_ROUTE(NEG_ROUTE), .POS_ROUTE(POS_ROUTE),
  .CMP_EXT_OUT(CMP_EXT_OUT), .WG_SUSPEND(WG_SUSPEND),
  .ADC_START(ADC_START), .TMR_RESET(TMR_RESET), .COMP_IRQ(COMP_IRQ),
  .WAKE(WAKE));

//--- tb/cmpc_tmr_model.sv
// timer-side model: timing pulses in, trigger count back
`timescale 1ns/1ps
module cmpc_tmr_model (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // pulses to the block
  output logic       instr_en,
  output logic       tfall_en,
  // triggers from the block
  input  wire logic  adc_start,
  output logic [7:0] adc_count
);
  logic [3:0] div_reg;
  always_ff @(posedge clk) begin
    div_reg <= srst ? 4'h0 : div_reg + 4'h1;
  end
  // instruction cycle is four core clocks
  always_ff @(posedge clk) begin
    instr_en <= !srst && div_reg[1:0] == 2'h3;
  end
  // prescaled timer clock falls once in sixteen
  always_ff @(posedge clk) begin
    tfall_en <= !srst && div_reg == 4'hF;
  end
  always_ff @(posedge clk) begin
    if (srst) adc_count <= 8'h00;
    else if (adc_start) adc_count <= adc_count + 8'h01;
  end
endmodule : cmpc_tmr_model

//--- tb/cmpc_ctrl_tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module cmpc_ctrl_tb;
  logic                 CORE_CLK, INSTR_CYCLE_EN, TMR_CLK_FALL_EN;
  logic                 SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic                 SLEEP = 1'b0, TMR_SRC_IS_CORE = 1'b0, rd_seen = 1'b0;
  cmpc_pkg::cmpc_addr_t REG_ADDR = 16'h0000;
  cmpc_pkg::cmpc_byte_t REG_WDATA = 8'h00, REG_RDATA;
  logic [1:0]           CMP_RAW = 2'h0, SHDN_SRC_EN = 2'h1, sel_code = 2'h0;
  cmpc_pkg::cmpc_trig_t ADC_TRIG_SEL = 2'h1, TMR_RST_SEL = 2'h1;
  logic [1:0]           ANALOG_EN, HYST_EN, CMP_EXT_OUT, COMP_IRQ;
  logic                 WG_SUSPEND, ADC_START, TMR_RESET, WAKE;
  logic [11:0]          NEG_ROUTE;
  logic [9:0]           POS_ROUTE;
  logic [7:0]           adc_count, lfsr_reg = 8'h4F, nadc = 8'h00;
  logic [4:0]           rise_t = 5'b10011, fall_t = 5'b11100;
  logic [4:0]           raw_t = 5'b10101, flag_t = 5'b11001;
  cmpc_pkg::cmpc_byte_t exp_q[$];
  int                   miscompares = 0, checks_done = 0, cycles = 0;

  cmpc_ctrl i_cmpc_ctrl (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CMP_RAW(CMP_RAW),
    .INSTR_CYCLE_EN(INSTR_CYCLE_EN), .TMR_CLK_FALL_EN(TMR_CLK_FALL_EN),
    .TMR_SRC_IS_CORE(TMR_SRC_IS_CORE), .SLEEP(SLEEP),
    .SHDN_SRC_EN(SHDN_SRC_EN), .ADC_TRIG_SEL(ADC_TRIG_SEL),
    .TMR_RST_SEL(TMR_RST_SEL), .ANALOG_EN(ANALOG_EN), .HYST_EN(HYST_EN),
    .NEG_ROUTE(NEG_ROUTE), .POS_ROUTE(POS_ROUTE),
    .CMP_EXT_OUT(CMP_EXT_OUT), .WG_SUSPEND(WG_SUSPEND),
    .ADC_START(ADC_START), .TMR_RESET(TMR_RESET), .COMP_IRQ(COMP_IRQ),
    .WAKE(WAKE));
  cmpc_tmr_model i_cmpc_tmr_model (.clk(CORE_CLK), .srst(SRST),
    .instr_en(INSTR_CYCLE_EN), .tfall_en(TMR_CLK_FALL_EN),
    .adc_start(ADC_START), .adc_count(adc_count));

  initial begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [5:0] nexp(input logic [2:0] c);
    return c[2:1] == 2'h3 ? 6'h01 << (c - 3'h2) : c[2] ? 6'h00 : 6'h01 << c;
  endfunction : nexp
  function automatic logic [4:0] pexp(input logic [2:0] c);
    return c >= 3'h5 ? 5'h01 << (c - 3'h3)
         : c[2:1] != 2'h0 ? 5'h00 : 5'h01 << c;
  endfunction : pexp
  // code 1 names comparator 1, code 2 comparator 2, others none
  function automatic logic pick(input logic [1:0] sel, input logic [1:0] v);
    return sel == `CMPC_TRIG_C1 ? v[0] : sel == `CMPC_TRIG_C2 ? v[1] : 1'b0;
  endfunction : pick

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [11:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : settle
  task automatic bus(input logic w, input cmpc_pkg::cmpc_addr_t a,
                     input cmpc_pkg::cmpc_byte_t d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= w;
    REG_RD <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
  endtask : bus

  // read data stands only in the cycle after the strobe
  always @(posedge CORE_CLK) begin
    rd_seen <= REG_RD;
    if (rd_seen === 1'b1)
      chk("read", 12'(REG_RDATA), 12'(exp_q.pop_front()));
  end
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    settle(2);
    SRST <= 1'b0;
    bus(1'b1, `CMPC_OFS_MIRROR, 8'hFF);
    bus(1'b1, 16'h099A, 8'hFF);
    for (int a = 16'h098F; a <= 16'h099A; a++)
      bus(1'b0, 16'(a), 8'h00);
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h82);
    bus(1'b1, `CMPC_OFS_C2_CON0, 8'h80);
    settle(2);
    chk("en", 12'(ANALOG_EN), 12'h003);
    chk("hys", 12'(HYST_EN), 12'h001);
    for (int i = 0; i < 6; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      sel_code = lfsr_reg[7:6];
      nadc += 8'(pick(sel_code, lfsr_reg[1:0] & ~CMP_RAW));
      CMP_RAW <= lfsr_reg[1:0];
      ADC_TRIG_SEL <= sel_code;
      TMR_RST_SEL <= sel_code ^ 2'h3;
      SHDN_SRC_EN <= sel_code ^ 2'h2;
      settle(14);
      bus(1'b0, `CMPC_OFS_MIRROR, 8'(lfsr_reg[1:0]));
      bus(1'b0, `CMPC_OFS_C1_CON0, {1'b1, lfsr_reg[0], 6'h02});
      chk("ext", 12'(CMP_EXT_OUT), 12'(lfsr_reg[1:0]));
      chk("wg", 12'(WG_SUSPEND),
          12'(|(lfsr_reg[1:0] & (sel_code ^ 2'h2))));
      chk("tmr", 12'(TMR_RESET),
          12'(pick(sel_code ^ 2'h3, lfsr_reg[1:0])));
    end
    chk("adc", 12'(adc_count), 12'(nadc));
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h92);
    settle(14);
    bus(1'b0, `CMPC_OFS_C1_CON0, {1'b1, ~lfsr_reg[0], 6'h12});
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h80);
    CMP_RAW <= 2'h0;
    bus(1'b1, `CMPC_OFS_IRQ_EN, 8'h01);
    settle(14);
    bus(1'b1, `CMPC_OFS_FLAG, 8'h03);
    // edges against rise-only, fall-only and both-on enable pairs, flag cleared after each
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `CMPC_OFS_C1_CON1, {6'h00, rise_t[i], fall_t[i]});
      CMP_RAW <= {1'b0, raw_t[i]};
      settle(14);
      SLEEP <= 1'b1;
      bus(1'b0, `CMPC_OFS_FLAG, 8'(flag_t[i]));
      chk("wake", 12'(WAKE), 12'(flag_t[i]));
      chk("irq", 12'(COMP_IRQ), 12'(flag_t[i]));
      SLEEP <= 1'b0;
      bus(1'b1, `CMPC_OFS_FLAG, 8'h01);
    end
    // disabled comparator still flags on enable and polarity toggles
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h00);
    settle(14);
    bus(1'b0, `CMPC_OFS_FLAG, 8'h01);
    chk("route", NEG_ROUTE & 12'h03F, 12'h000);
    bus(1'b1, `CMPC_OFS_FLAG, 8'h01);
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h10);
    settle(14);
    bus(1'b0, `CMPC_OFS_C1_CON0, 8'h50);
    bus(1'b0, `CMPC_OFS_FLAG, 8'h01);
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h80);
    for (int c = 0; c < 8; c++) begin
      lfsr_reg = lfsr(lfsr_reg);
      bus(1'b1, `CMPC_OFS_C1_NSEL, {lfsr_reg[7:3], 3'(c)});
      bus(1'b1, `CMPC_OFS_C2_PSEL, {lfsr_reg[7:3], 3'(c)});
      bus(1'b0, `CMPC_OFS_C1_NSEL, 8'(c));
      chk("neg", 12'(NEG_ROUTE[5:0]), 12'(nexp(3'(c))));
      chk("pos", 12'(POS_ROUTE[9:5]), 12'(pexp(3'(c))));
    end
    // sync output stands still while the core-clocked timer sleeps
    bus(1'b1, `CMPC_OFS_C1_CON0, 8'h81);
    SLEEP <= 1'b1;
    TMR_SRC_IS_CORE <= 1'b1;
    CMP_RAW <= 2'h0;
    settle(40);
    chk("frozen", 12'(CMP_EXT_OUT[0]), 12'h001);
    bus(1'b0, `CMPC_OFS_C1_CON0, 8'h81);
    SLEEP <= 1'b0;
    settle(40);
    chk("synced", 12'(CMP_EXT_OUT[0]), 12'h000);
    test_done();
  end
endmodule : cmpc_ctrl_tb
